// *** src/pet_pkg.sv ***
// package: constants and types for the pwm external trigger control
package pet_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned FAST_OSC_PERIOD_NS = 125;
	localparam int unsigned SLOW_CLK_PERIOD_NS = 30500; // 30.5 us
	localparam int unsigned FAST_TICK_CYCLES   =
		FAST_OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SLOW_TICK_CYCLES   =
		SLOW_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_CNT_W         = 12;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL0  = 4'h0;
	localparam logic [3:0] OFS_TRIG   = 4'h1;
	localparam logic [3:0] OFS_DUTY   = 4'h2;
	localparam logic [3:0] OFS_PERIOD = 4'h3;
	localparam logic [3:0] OFS_COUNT  = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;

	// control register 0 fields
	localparam int unsigned CTRL0_RUN_BIT    = 0;
	localparam int unsigned CTRL0_CLK_SEL_LO = 1;
	localparam int unsigned CTRL0_CLK_SEL_HI = 2;
	localparam int unsigned CTRL0_CLR_GATE   = 3;
	// trigger control register fields
	localparam int unsigned TRIG_MODE_LO = 0;
	localparam int unsigned TRIG_MODE_HI = 1;
	localparam int unsigned TRIG_PIN_SEL = 2;
	localparam int unsigned TRIG_POL_LO  = 3;
	localparam int unsigned TRIG_POL_HI  = 4;
	// status register fields
	localparam int unsigned STAT_ACTIVE = 0;
	localparam int unsigned STAT_FLAG   = 1;

	// pwm clock selections
	localparam logic [1:0] CLK_SEL_FAST_OSC = 2'h0;
	localparam logic [1:0] CLK_SEL_SLOW     = 2'h1;

	// polarity codes
	localparam logic [1:0] POL_RISE_START = 2'h1;
	localparam logic [1:0] POL_FALL_START = 2'h2;

	// reset values
	localparam logic [15:0] DUTY_RST   = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TM_SOFT        = 2'h0,
		TM_SOFT_OR_EXT = 2'h1,
		TM_EXT         = 2'h2,
		TM_EXT_CLEAR   = 2'h3
	} pet_mode_e;

	typedef enum logic [1:0] {
		EXT_IDLE = 2'h1,
		EXT_RUN  = 2'h2
	} pet_ext_state_e;

	typedef struct packed {
		pet_mode_e  mode;
		logic       pin_sel;
		logic [1:0] polarity;
	} pet_trig_cfg_s;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} pet_event_s;

endpackage

// *** src/pet_pwm_counter.sv ***
// module: pwm counter with duty and period buffers
`timescale 1ns/10ps
module pet_pwm_counter
	import pet_pkg::*;
#(
	parameter int unsigned W = DATA_W
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_b_i,
	input  wire logic         pwm_tick_i,
	input  wire logic         run_en_i,
	input  wire logic         clear_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] duty_i,
	input  wire logic [W-1:0] period_i,
	output logic      [W-1:0] count_o,
	output logic      [W-1:0] duty_buf_o,
	output logic      [W-1:0] period_buf_o,
	output logic              flag_o,
	output logic              active_o
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic [W-1:0] dbuf_reg;
	logic [W-1:0] dbuf_next;
	logic [W-1:0] pbuf_reg;
	logic [W-1:0] pbuf_next;
	logic         flag_reg;
	logic         flag_next;
	logic         active_reg;
	logic         active_next;

	// clear wins over the pwm tick; a tick while active counts once
	// more even if run was just dropped
	always_comb begin
		count_next  = count_reg;
		dbuf_next   = dbuf_reg;
		pbuf_next   = pbuf_reg;
		flag_next   = flag_reg;
		active_next = active_reg;
		if (clear_i) begin
			count_next = '0;
			dbuf_next  = duty_i;
			pbuf_next  = period_i;
			flag_next  = 1'b1;
		end else if (pwm_tick_i) begin
			active_next = run_en_i;
			if (active_reg) begin
				if (count_reg == pbuf_reg) begin
					count_next = '0;
					dbuf_next  = duty_i;
					pbuf_next  = period_i;
					flag_next  = 1'b1;
				end else begin
					count_next = count_reg + 1'b1;
					if (count_reg == dbuf_reg) begin
						flag_next = 1'b0;
					end
				end
			end
		end else if (load_i) begin
			dbuf_next = duty_i;
			pbuf_next = period_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			count_reg  <= '0;
			dbuf_reg   <= '0;
			pbuf_reg   <= '1;
			flag_reg   <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			count_reg  <= count_next;
			dbuf_reg   <= dbuf_next;
			pbuf_reg   <= pbuf_next;
			flag_reg   <= flag_next;
			active_reg <= active_next;
		end
	end

	assign count_o      = count_reg;
	assign duty_buf_o   = dbuf_reg;
	assign period_buf_o = pbuf_reg;
	assign flag_o       = flag_reg;
	assign active_o     = active_reg;

	chk_period_wrap: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		(pwm_tick_i && active_reg && !clear_i && count_reg == pbuf_reg)
		|=> (count_reg == '0 && flag_reg && dbuf_reg == $past(duty_i)))
		else $error("period match did not wrap and reload");

endmodule

// *** src/pet_trig_ctrl.sv ***
// module: external trigger control of the pwm counter
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
module pet_trig_ctrl
	import pet_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_b_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              wr_stb_i,
	input  wire logic              rd_stb_i,
	output logic      [DATA_W-1:0] rd_data_o,
	input  wire logic              event_input_0_i,
	input  wire logic              event_input_1_i,
	output logic                   pwm_output_flag_o,
	output logic                   count_active_status_o
);

	// ---------------------------------------------------------------
	// polarity decode
	// ---------------------------------------------------------------
	// codes 00 and 11 give no edges and a permanent start level
	function automatic logic start_edge(pet_event_s e, logic [1:0] p);
		start_edge = (p == POL_RISE_START) ? e.rise :
			(p == POL_FALL_START) ? e.fall : 1'b0;
	endfunction

	function automatic logic stop_edge(pet_event_s e, logic [1:0] p);
		stop_edge = (p == POL_RISE_START) ? e.fall :
			(p == POL_FALL_START) ? e.rise : 1'b0;
	endfunction

	function automatic logic start_level(pet_event_s e, logic [1:0] p);
		start_level = (p == POL_FALL_START) ? ~e.level :
			(p == POL_RISE_START) ? e.level : 1'b1;
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic                  run_reg;
	logic                  run_next;
	logic [1:0]            clk_sel_reg;
	logic [1:0]            clk_sel_next;
	logic                  clr_gate_reg;
	logic                  clr_gate_next;
	pet_trig_cfg_s         trig_reg;
	pet_trig_cfg_s         trig_next;
	logic [DATA_W-1:0]     duty_reg;
	logic [DATA_W-1:0]     duty_next;
	logic [DATA_W-1:0]     period_reg;
	logic [DATA_W-1:0]     period_next;
	logic [DATA_W-1:0]     rd_data_reg;
	logic [DATA_W-1:0]     rd_data_next;
	logic                  load_reg;
	logic                  load_next;
	logic [TICK_CNT_W-1:0] fast_cnt_reg;
	logic [TICK_CNT_W-1:0] fast_cnt_next;
	logic [TICK_CNT_W-1:0] slow_cnt_reg;
	logic [TICK_CNT_W-1:0] slow_cnt_next;
	pet_ext_state_e        ext_state_reg;
	pet_ext_state_e        ext_state_next;

	logic              fast_tick;
	logic              slow_tick;
	logic              sample_tick;
	logic              pwm_tick;
	logic              sel_pin;
	pet_event_s        evt;
	logic              ev_start;
	logic              ev_stop;
	logic              lvl_start;
	logic              run_en;
	logic              ext_clear;
	logic              sw_clear;
	logic              cnt_clear;
	logic [DATA_W-1:0] count;
	logic              flag;
	logic              active;

	// ---------------------------------------------------------------
	// clock ticks and input selection
	// ---------------------------------------------------------------
	assign fast_tick = (fast_cnt_reg ==
		TICK_CNT_W'(FAST_TICK_CYCLES - 1));
	assign slow_tick = (slow_cnt_reg ==
		TICK_CNT_W'(SLOW_TICK_CYCLES - 1));
	assign sample_tick = (clk_sel_reg == CLK_SEL_FAST_OSC) ?
		fast_tick : slow_tick;
	// other selections stand for a system-rate pwm clock
	assign pwm_tick = (clk_sel_reg == CLK_SEL_FAST_OSC) ? fast_tick :
		(clk_sel_reg == CLK_SEL_SLOW) ? slow_tick : 1'b1;
	// pin select is static in use; a change may show one false edge
	assign sel_pin = trig_reg.pin_sel ? event_input_1_i
		: event_input_0_i;

	pet_trig_sampler u_sampler (
		.clk_sys_i     (clk_sys_i),
		.rst_b_i       (rst_b_i),
		.pin_i         (sel_pin),
		.sample_tick_i (sample_tick),
		.evt_o         (evt)
	);

	assign ev_start  = start_edge(evt, trig_reg.polarity);
	assign ev_stop   = stop_edge(evt, trig_reg.polarity);
	assign lvl_start = start_level(evt, trig_reg.polarity);

	// ---------------------------------------------------------------
	// mode decode: run enable and external clear
	// ---------------------------------------------------------------
	always_comb begin
		run_en    = run_reg;
		ext_clear = 1'b0;
		case (trig_reg.mode)
			TM_SOFT: begin
				run_en = run_reg;
			end
			TM_SOFT_OR_EXT: begin
				run_en    = run_reg & lvl_start;
				ext_clear = ev_stop;
			end
			TM_EXT: begin
				run_en    = run_reg & (ext_state_reg == EXT_RUN);
				ext_clear = run_reg & ev_stop;
			end
			TM_EXT_CLEAR: begin
				run_en    = run_reg;
				ext_clear = ev_stop & ~(clr_gate_reg & flag);
			end
			default: begin
				run_en = run_reg;
			end
		endcase
	end

	assign sw_clear  = wr_stb_i & (addr_i == OFS_COUNT);
	assign cnt_clear = ext_clear | sw_clear;

	// ---------------------------------------------------------------
	// register file, tick counters and external run state
	// ---------------------------------------------------------------
	always_comb begin
		run_next       = run_reg;
		clk_sel_next   = clk_sel_reg;
		clr_gate_next  = clr_gate_reg;
		trig_next      = trig_reg;
		duty_next      = duty_reg;
		period_next    = period_reg;
		rd_data_next   = '0;
		fast_cnt_next  = fast_tick ? '0 : fast_cnt_reg + 1'b1;
		slow_cnt_next  = slow_tick ? '0 : slow_cnt_reg + 1'b1;
		ext_state_next = ext_state_reg;
		// paused writes reach the buffers a cycle later when that cycle has no pwm tick
		load_next = wr_stb_i & ~active &
			(addr_i == OFS_DUTY || addr_i == OFS_PERIOD);
		if (wr_stb_i) begin
			case (addr_i)
				OFS_CTRL0: begin
					run_next      = wr_data_i[CTRL0_RUN_BIT];
					clk_sel_next  =
						wr_data_i[CTRL0_CLK_SEL_HI:CTRL0_CLK_SEL_LO];
					clr_gate_next = wr_data_i[CTRL0_CLR_GATE];
				end
				OFS_TRIG: begin
					trig_next.mode = pet_mode_e'(
						wr_data_i[TRIG_MODE_HI:TRIG_MODE_LO]);
					trig_next.pin_sel  = wr_data_i[TRIG_PIN_SEL];
					trig_next.polarity =
						wr_data_i[TRIG_POL_HI:TRIG_POL_LO];
				end
				OFS_DUTY:   duty_next = wr_data_i;
				OFS_PERIOD: period_next = wr_data_i;
				default:    run_next = run_reg;
			endcase
		end
		if (rd_stb_i) begin
			case (addr_i)
				OFS_CTRL0: begin
					rd_data_next[CTRL0_RUN_BIT] = run_reg;
					rd_data_next[CTRL0_CLK_SEL_HI:CTRL0_CLK_SEL_LO] =
						clk_sel_reg;
					rd_data_next[CTRL0_CLR_GATE] = clr_gate_reg;
				end
				OFS_TRIG: begin
					rd_data_next[TRIG_MODE_HI:TRIG_MODE_LO] =
						trig_reg.mode;
					rd_data_next[TRIG_PIN_SEL] = trig_reg.pin_sel;
					rd_data_next[TRIG_POL_HI:TRIG_POL_LO] =
						trig_reg.polarity;
				end
				OFS_DUTY:   rd_data_next = duty_reg;
				OFS_PERIOD: rd_data_next = period_reg;
				OFS_COUNT:  rd_data_next = count;
				OFS_STATUS: begin
					rd_data_next[STAT_ACTIVE] = active;
					rd_data_next[STAT_FLAG]   = flag;
				end
				default:    rd_data_next = '0;
			endcase
		end
		// edges with run low are dropped and the state falls idle
		case (ext_state_reg)
			EXT_IDLE: begin
				if (run_reg && ev_start && trig_reg.mode == TM_EXT) begin
					ext_state_next = EXT_RUN;
				end
			end
			EXT_RUN: begin
				if (!run_reg || ev_stop || trig_reg.mode != TM_EXT) begin
					ext_state_next = EXT_IDLE;
				end
			end
			default: ext_state_next = EXT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			run_reg       <= 1'b0;
			clk_sel_reg   <= CLK_SEL_FAST_OSC;
			clr_gate_reg  <= 1'b0;
			trig_reg      <= '{mode: TM_SOFT, pin_sel: 1'b0,
				polarity: POL_RISE_START};
			duty_reg      <= DUTY_RST;
			period_reg    <= PERIOD_RST;
			rd_data_reg   <= '0;
			load_reg      <= 1'b0;
			fast_cnt_reg  <= '0;
			slow_cnt_reg  <= '0;
			ext_state_reg <= EXT_IDLE;
		end else begin
			run_reg       <= run_next;
			clk_sel_reg   <= clk_sel_next;
			clr_gate_reg  <= clr_gate_next;
			trig_reg      <= trig_next;
			duty_reg      <= duty_next;
			period_reg    <= period_next;
			rd_data_reg   <= rd_data_next;
			load_reg      <= load_next;
			fast_cnt_reg  <= fast_cnt_next;
			slow_cnt_reg  <= slow_cnt_next;
			ext_state_reg <= ext_state_next;
		end
	end

	pet_pwm_counter #(
		.W (DATA_W)
	) u_counter (
		.clk_sys_i    (clk_sys_i),
		.rst_b_i      (rst_b_i),
		.pwm_tick_i   (pwm_tick),
		.run_en_i     (run_en),
		.clear_i      (cnt_clear),
		.load_i       (load_reg),
		.duty_i       (duty_reg),
		.period_i     (period_reg),
		.count_o      (count),
		.duty_buf_o   (),
		.period_buf_o (),
		.flag_o       (flag),
		.active_o     (active)
	);

	assign rd_data_o             = rd_data_reg;
	assign pwm_output_flag_o     = flag;
	assign count_active_status_o = active;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	chk_soft_mode_run: assert property (
		trig_reg.mode == TM_SOFT |-> run_en == run_reg && !ext_clear)
		else $error("software mode saw external influence");
	chk_level_hold: assert property (
		trig_reg.mode == TM_SOFT_OR_EXT && !lvl_start |-> !run_en)
		else $error("counter enabled at stop level");
	chk_stop_clears: assert property (
		trig_reg.mode == TM_SOFT_OR_EXT && ev_stop |=> count == '0)
		else $error("external stop did not clear counter");
	chk_clear_reload: assert property (
		ext_clear |=> u_counter.dbuf_reg == $past(duty_reg)
		&& u_counter.pbuf_reg == $past(period_reg))
		else $error("external clear did not reload buffers");
	chk_ext_start_run: assert property (
		ext_state_reg == EXT_IDLE && trig_reg.mode == TM_EXT
		&& run_reg && run_next && ev_start |=> ext_state_reg == EXT_RUN)
		else $error("start edge ignored in external mode");
	chk_ext_run_gate: assert property (
		trig_reg.mode == TM_EXT && !run_reg |-> !run_en && !ext_clear)
		else $error("external edge acted with run low");
	chk_clear_edge: assert property (
		trig_reg.mode == TM_EXT_CLEAR && ev_stop && !clr_gate_reg
		|-> ext_clear)
		else $error("clear edge not taken");
	chk_clear_gate: assert property (
		trig_reg.mode == TM_EXT_CLEAR && clr_gate_reg && flag
		|-> !ext_clear)
		else $error("clear taken while gated");
	chk_run_stop: assert property (
		active && pwm_tick && !run_en && !cnt_clear
		|=> !active && count ==
		(($past(count) == $past(u_counter.pbuf_reg)) ? '0 :
		$past(count) + 1'b1))
		else $error("stop did not take one last count");
	chk_sample_rate: assert property (
		clk_sel_reg != CLK_SEL_FAST_OSC && fast_tick && !slow_tick
		|-> !sample_tick)
		else $error("fast sampling used off fast oscillator");

	cov_ext_start:   cover property (ext_state_reg == EXT_RUN && active);
	cov_level_start: cover property (
		trig_reg.mode == TM_SOFT_OR_EXT && evt.rise ##1 active);
	cov_gated_clear: cover property (
		trig_reg.mode == TM_EXT_CLEAR && clr_gate_reg && flag && ev_stop);

endmodule

// *** src/pet_trig_sampler.sv ***
// module: synchroniser and noise filter for one trigger input
`timescale 1ns/10ps
module pet_trig_sampler
	import pet_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic       pin_i,
	input  wire logic       sample_tick_i,
	output pet_event_s      evt_o
);

	logic sync1_reg;
	logic sync2_reg;
	logic samp_reg;
	logic samp_next;
	logic level_reg;
	logic level_next;
	logic rise_reg;
	logic rise_next;
	logic fall_reg;
	logic fall_next;

	// ---------------------------------------------------------------
	// filter: a level is taken only after two equal samples in a row
	// ---------------------------------------------------------------
	// a pulse of one sample period or less never yields two samples
	always_comb begin
		samp_next  = samp_reg;
		level_next = level_reg;
		if (sample_tick_i) begin
			samp_next = sync2_reg;
			if (sync2_reg == samp_reg) begin
				level_next = sync2_reg;
			end
		end
		rise_next = level_next & ~level_reg;
		fall_next = ~level_next & level_reg;
	end

	// sync1 feeds only sync2
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			samp_reg  <= 1'b0;
			level_reg <= 1'b0;
			rise_reg  <= 1'b0;
			fall_reg  <= 1'b0;
		end else begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			samp_reg  <= samp_next;
			level_reg <= level_next;
			rise_reg  <= rise_next;
			fall_reg  <= fall_next;
		end
	end

	assign evt_o = '{level: level_reg, rise: rise_reg, fall: fall_reg};

endmodule

// *** testbench/pet_pin_model.sv ***
// partner: behavioural driver of the two external event pins
`timescale 1ns/10ps
module pet_pin_model (
	input  wire logic clk_sys_i,
	output logic      event_input_0_o,
	output logic      event_input_1_o
);

	// ------------------------------------------------
	// pin levels
	// ------------------------------------------------
	// both pins rest low until a scenario moves them
	initial begin
		event_input_0_o = 1'b0;
		event_input_1_o = 1'b0;
	end

	// change one pin right after an edge, then hold it n cycles;
	// callers keep real levels for whole pwm clocks
	task automatic hold(input int p, input logic v, input int n);
		@(posedge clk_sys_i);
		if (p == 0) begin
			event_input_0_o <= v;
		end else begin
			event_input_1_o <= v;
		end
		repeat (n) @(posedge clk_sys_i);
	endtask

endmodule

// *** testbench/pet_trig_ctrl_tb.sv ***
// testbench: self-checking bench for the pwm external trigger control
`timescale 1ns/10ps
module pet_trig_ctrl_tb;
	import pet_pkg::*;
	localparam int SETTLE = 100;
	logic              clk_sys_i;
	logic              rst_b_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wr_data_i;
	logic              wr_stb_i;
	logic              rd_stb_i;
	logic [DATA_W-1:0] rd_data_o;
	logic              ev0;
	logic              ev1;
	logic              flag;
	logic              stat;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] d0;
	int                mreg [4];
	int                bad_count;
	int                n_checks;
	int                w;

	pet_trig_ctrl pet_trig_ctrl_i (
		.clk_sys_i             (clk_sys_i),
		.rst_b_i               (rst_b_i),
		.addr_i                (addr_i),
		.wr_data_i             (wr_data_i),
		.wr_stb_i              (wr_stb_i),
		.rd_stb_i              (rd_stb_i),
		.rd_data_o             (rd_data_o),
		.event_input_0_i       (ev0),
		.event_input_1_i       (ev1),
		.pwm_output_flag_o     (flag),
		.count_active_status_o (stat)
	);

	pet_pin_model pet_pin_model_i (
		.clk_sys_i       (clk_sys_i),
		.event_input_0_o (ev0),
		.event_input_1_o (ev1)
	);

	// one clock for bus and pwm, so register updates never cross clocks
	always #5 clk_sys_i = ~clk_sys_i;

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// write also updates the bench register model
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys_i);
		wr_stb_i  <= 1'b1;
		addr_i    <= a;
		wr_data_i <= v;
		@(posedge clk_sys_i);
		wr_stb_i <= 1'b0;
		if (a < 4) mreg[a] = int'(v);
	endtask

	// read data stands only in the cycle after the strobe edge
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_sys_i);
		rd_stb_i <= 1'b1;
		addr_i   <= a;
		@(posedge clk_sys_i);
		rd_stb_i <= 1'b0;
		#1 v = rd_data_o;
	endtask

	task automatic rchk(input logic [3:0] a);
		rd(a, d);
		chk("register", 16'(mreg[a]), d);
	endtask

	// bounded wait for the status level; looks 1 ns after an edge so
	// the value launched by that edge is already visible
	task automatic wait_stat(input logic e, input int lim);
		int i;
		#1;
		for (i = 0; i < lim && stat !== e; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk("status", 16'(e), 16'(stat));
		if (stat !== e) conclude();
	endtask

	task automatic pin(input int p, input logic v, input int n);
		pet_pin_model_i.hold(p, v, n);
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		bad_count++;
		conclude();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		rst_b_i   = 1'b0;
		addr_i    = '0;
		wr_data_i = '0;
		wr_stb_i  = 1'b0;
		rd_stb_i  = 1'b0;
		bad_count = 0;
		n_checks  = 0;
		mreg      = '{0, 32'h0008, 0, 32'hFFFF};
		w         = $urandom(32'hF2553A7F);
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		// reset values and an unmapped read
		for (int a = 0; a < 4; a++) rchk(4'(a));
		rd(OFS_STATUS, d);
		chk("status reg", 16'h0000, d);
		rd(4'hF, d);
		chk("unmapped", 16'h0000, d);
		// software mode ignores the pins; short period wraps
		wr(OFS_DUTY, 16'h0002);
		wr(OFS_PERIOD, 16'h0005);
		wr(OFS_CTRL0, 16'h0001);
		wait_stat(1'b1, 40);
		pin(0, 1'b1, 50);
		pin(0, 1'b0, 50);
		chk("mode 00 run", 16'h0001, 16'(stat));
		for (int k = 0; k < 6; k++) begin
			repeat ($urandom % 17 + 3) @(posedge clk_sys_i);
			rd(OFS_COUNT, d);
			chk("count wrap", 16'h0001, 16'(d <= 16'h0005));
		end
		wr(OFS_CTRL0, 16'h0000);
		wait_stat(1'b0, 40);
		// buffer writes here are made while stopped
		wr(OFS_PERIOD, 16'hFFFF);
		wr(OFS_DUTY, 16'h0100);
		// start level gating and stop clear, rising start polarity
		wr(OFS_TRIG, 16'h0009);
		wr(OFS_CTRL0, 16'h0001);
		repeat (SETTLE) @(posedge clk_sys_i);
		chk("held at stop level", 16'h0000, 16'(stat));
		pin(0, 1'b1, SETTLE);
		chk("start level", 16'h0001, 16'(stat));
		pin(0, 1'b0, SETTLE);
		chk("stop edge", 16'h0000, 16'(stat));
		rd(OFS_COUNT, d);
		chk("stop clears", 16'h0001, 16'(d <= 16'h0001));
		chk("clear flag", 16'h0001, 16'(flag));
		rchk(OFS_TRIG);
		// falling start polarity
		wr(OFS_TRIG, 16'h0011);
		wait_stat(1'b1, SETTLE);
		pin(0, 1'b1, SETTLE);
		chk("high stops", 16'h0000, 16'(stat));
		// second pin selected, first pin left at stop level
		wr(OFS_TRIG, 16'h0015);
		wait_stat(1'b1, SETTLE);
		pin(1, 1'b1, SETTLE);
		chk("pin 1 stops", 16'h0000, 16'(stat));
		pin(1, 1'b0, 10);
		pin(0, 1'b0, 10);
		// edge only mode: edges without run are dropped
		wr(OFS_CTRL0, 16'h0000);
		wait_stat(1'b0, 40);
		wr(OFS_TRIG, 16'h000A);
		pin(0, 1'b1, SETTLE);
		chk("edge without run", 16'h0000, 16'(stat));
		pin(0, 1'b0, SETTLE);
		wr(OFS_CTRL0, 16'h0001);
		repeat (SETTLE) @(posedge clk_sys_i);
		chk("run alone", 16'h0000, 16'(stat));
		pin(0, 1'b1, SETTLE);
		chk("edge start", 16'h0001, 16'(stat));
		pin(0, 1'b0, SETTLE);
		chk("edge stop", 16'h0000, 16'(stat));
		// clear mode: run bit governs, gate blocks clear at flag high
		wr(OFS_TRIG, 16'h000B);
		wait_stat(1'b1, SETTLE);
		wr(OFS_COUNT, 16'($urandom));
		repeat (2) @(posedge clk_sys_i);
		chk("count write flag", 16'h0001, 16'(flag));
		wr(OFS_CTRL0, 16'h0009);
		pin(0, 1'b1, SETTLE);
		rd(OFS_COUNT, d0);
		pin(0, 1'b0, SETTLE);
		rd(OFS_COUNT, d);
		chk("gated clear", 16'h0001, 16'(d > d0));
		wr(OFS_CTRL0, 16'h0001);
		wr(OFS_DUTY, 16'h0003);
		pin(0, 1'b1, SETTLE);
		rd(OFS_COUNT, d0);
		pin(0, 1'b0, $urandom % 6 + 1);
		pin(0, 1'b1, SETTLE);
		rd(OFS_COUNT, d);
		chk("noise pulse", 16'h0001, 16'(d > d0));
		pin(0, 1'b0, 150);
		rd(OFS_COUNT, d);
		chk("edge clear", 16'h0001, 16'(d < 16'h0010));
		chk("duty reload", 16'h0000, 16'(flag));
		chk("run kept", 16'h0001, 16'(stat));
		// system-rate pwm clock: one count per cycle between two reads
		wr(OFS_CTRL0, 16'h0005);
		wait_stat(1'b1, 4);
		rd(OFS_COUNT, d0);
		rd(OFS_COUNT, d);
		chk("system rate count", 16'h0002, d - d0);
		wr(OFS_CTRL0, 16'h0000);
		wait_stat(1'b0, 40);
		wr(OFS_CTRL0, 16'h0001);
		wait_stat(1'b1, 40);
		wr(OFS_CTRL0, 16'h0000);
		wait_stat(1'b0, 40);
		for (int a = 0; a < 4; a++) rchk(4'(a));
		conclude();
	end

endmodule
